/* File: testbench/ccu_top_tb.sv */
// Purpose: self-checking bench of the crc calculation unit
// Assumes: apb master driven on rising edges, slave answers in its own time
// Notes: expected crc values come from a bitwise model kept in this file
`timescale 1ns/1ps
`default_nettype none
module ccu_top_tb
   import ccu_pkg::*;
;
   //==============================================================
   // clock, bus and bookkeeping
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h00000000;
   logic [3:0] pstrb = 4'h0;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   int failures = 0;
   int n_compared = 0;
   int cycles = 0;
   int last_lat;
   logic [31:0] m_crc, m_init, m_coeff;
   logic [1:0] m_wsel, m_inrev;
   logic m_outrev;

   // 25 MHz bus clock
   always #20 pclk = ~pclk;

   ccu_top u_dut (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
      .pslverr(pslverr)
   );

   //==============================================================
   // reporting
   task automatic print_verdict();
      $display("compared %0d, mismatches %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      n_compared++;
      if (got !== exp) begin
         failures++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask

   // hang guard, far above the few hundred cycles the tests need
   always @(posedge pclk) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         failures++;
         $display("ERROR timeout expected done seen hung");
         print_verdict();
      end
   end

   //==============================================================
   // reference model
   function automatic logic [31:0] wmask(input logic [1:0] w);
      case (w)
         2'h1: return 32'h0000ffff;
         2'h2: return 32'h000000ff;
         2'h3: return 32'h0000007f;
         default: return 32'hffffffff;
      endcase
   endfunction

   // reverse bit order inside every group of g bits
   function automatic logic [31:0] rev_grp(input logic [31:0] x, input int g);
      logic [31:0] y;
      for (int i = 0; i < 32; i++) begin
         y[i] = x[(i / g) * g + g - 1 - (i % g)];
      end
      return y;
   endfunction

   function automatic logic [31:0] exp_out();
      return m_outrev ? rev_grp(m_crc, 32) : m_crc;
   endfunction

   // mod-2 division, msb first, highest byte first
   task automatic feed(input logic [31:0] d, input int nb);
      logic [31:0] msk;
      logic fb;
      msk = wmask(m_wsel);
      for (int i = nb - 1; i >= 0; i--) begin
         for (int b = 7; b >= 0; b--) begin
            fb = ((m_crc & (msk ^ (msk >> 1))) != 0) ^ d[8 * i + b];
            m_crc = (m_crc << 1) & msk;
            if (fb) begin
               m_crc = m_crc ^ (m_coeff & msk);
            end
         end
      end
   endtask

   //==============================================================
   // apb master: hold the request until pready is seen at an edge
   task automatic acc(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                      input logic [31:0] exp, input logic eerr, input string what);
      logic [31:0] rdv;
      logic err;
      last_lat = 0;
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      pstrb <= wr ? s : 4'h0;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         last_lat++;
      end while (pready !== 1'b1);
      rdv = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
      chk({what, " pslverr"}, {31'h0, eerr}, {31'h0, err});
      if (!wr) begin
         chk(what, exp, rdv);
      end
   endtask

   task automatic set_ctrl(input logic o, input logic [1:0] ir, input logic [1:0] w, input logic r);
      m_outrev = o;
      m_inrev = ir;
      m_wsel = w;
      acc(1'b1, ADDR_CTRL, {24'h0, o, ir, w, 2'h0, r}, STRB_WORD, 0, 1'b0, "ctrl write");
      if (r) begin
         m_crc = m_init & wmask(w);
      end
   endtask

   task automatic data_w(input logic [31:0] d);
      acc(1'b1, ADDR_DATA, d, STRB_WORD, 0, 1'b0, "data write");
      feed((m_inrev == 2'h0) ? d : rev_grp(d, 4 << m_inrev), 4);
   endtask

   task automatic rd_crc(input string what);
      acc(1'b0, ADDR_DATA, 0, 4'h0, exp_out(), 1'b0, what);
   endtask

   //==============================================================
   // scenarios
   task automatic t_reset();
      acc(1'b0, ADDR_DATA, 0, 4'h0, RST_DATA, 1'b0, "data reset");
      acc(1'b0, ADDR_SCRATCH, 0, 4'h0, 32'h0, 1'b0, "scratch reset");
      acc(1'b0, ADDR_CTRL, 0, 4'h0, 32'h0, 1'b0, "ctrl reset");
      acc(1'b0, ADDR_INIT, 0, 4'h0, RST_INIT, 1'b0, "init reset");
      acc(1'b0, ADDR_COEFF, 0, 4'h0, RST_COEFF, 1'b0, "coeff reset");
      acc(1'b0, 8'h0c, 0, 4'h0, 32'h0, 1'b1, "unmapped read");
      $display("test reset done");
   endtask

   task automatic t_word();
      set_ctrl(1'b0, REV_NONE, WSEL_32, 1'b1);
      data_w(32'h12345678);
      rd_crc("crc word one");
      // a stalled read waits no longer than a step may run
      chk("step latency", 32'h1, {31'h0, last_lat <= CALC_CYCLES_MAX});
      data_w(32'hdeadbeef);
      rd_crc("crc accumulated");
      set_ctrl(1'b0, REV_NONE, WSEL_32, 1'b0);
      rd_crc("crc after zero reset bit");
      acc(1'b0, ADDR_CTRL, 0, 4'h0, 32'h0, 1'b0, "reset bit clears");
      $display("test word done");
   endtask

   task automatic t_narrow();
      set_ctrl(1'b0, REV_NONE, WSEL_32, 1'b1);
      acc(1'b1, ADDR_DATA, 32'ha5a5a5a5, 4'h1, 0, 1'b0, "byte write");
      feed(32'h000000a5, 1);
      acc(1'b1, ADDR_DATA, 32'h5a3c5a3c, 4'hc, 0, 1'b0, "half write");
      feed(32'h00005a3c, 2);
      acc(1'b1, ADDR_DATA, 32'h71717171, 4'h8, 0, 1'b0, "lane3 write");
      feed(32'h00000071, 1);
      rd_crc("crc narrow");
      acc(1'b1, ADDR_DATA, 32'h11111111, 4'h5, 0, 1'b1, "data split lanes");
      acc(1'b1, ADDR_SCRATCH, 32'h11, 4'h1, 0, 1'b1, "scratch byte write");
      acc(1'b1, ADDR_CTRL, 32'h81, 4'h3, 0, 1'b1, "ctrl half write");
      acc(1'b1, ADDR_COEFF, 32'h1, 4'h1, 0, 1'b1, "coeff byte write");
      rd_crc("crc after refusals");
      $display("test narrow done");
   endtask

   task automatic t_reverse();
      for (int m = 0; m < 4; m++) begin
         set_ctrl(1'b0, m[1:0], WSEL_32, 1'b1);
         data_w(32'h12345678);
         rd_crc("crc input reverse");
      end
      set_ctrl(1'b1, REV_NONE, WSEL_32, 1'b1);
      // reset bit was written as one, only the stored fields come back
      acc(1'b0, ADDR_CTRL, 0, 4'h0, 32'h80, 1'b0, "reset bit self clears");
      data_w(32'h0badcafe);
      rd_crc("crc output reverse");
      $display("test reverse done");
   endtask

   task automatic t_width();
      m_coeff = 32'h1edc6f41;
      m_init = 32'h89abcdef;
      acc(1'b1, ADDR_COEFF, m_coeff, STRB_WORD, 0, 1'b0, "coeff write");
      acc(1'b0, ADDR_COEFF, 0, 4'h0, m_coeff, 1'b0, "coeff readback");
      acc(1'b1, ADDR_INIT, m_init, STRB_WORD, 0, 1'b0, "init write");
      for (int w = 0; w < 4; w++) begin
         set_ctrl(1'b0, REV_NONE, w[1:0], 1'b1);
         rd_crc("crc init load");
         data_w(32'hc0ffee11);
         rd_crc("crc width");
      end
      $display("test width done");
   endtask

   task automatic t_scratch();
      acc(1'b1, ADDR_SCRATCH, 32'h123456c3, STRB_WORD, 0, 1'b0, "scratch write");
      set_ctrl(1'b0, REV_NONE, WSEL_32, 1'b1);
      acc(1'b0, ADDR_SCRATCH, 0, 4'h0, 32'h000000c3, 1'b0, "scratch kept");
      $display("test scratch done");
   endtask

   //==============================================================
   // main sequence
   initial begin
      m_crc = RST_DATA;
      m_init = RST_INIT;
      m_coeff = RST_COEFF;
      m_wsel = WSEL_32;
      m_inrev = REV_NONE;
      m_outrev = 1'b0;
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      t_reset();
      t_word();
      t_narrow();
      t_reverse();
      t_width();
      t_scratch();
      print_verdict();
   end
endmodule
`default_nettype wire

/* File: verilog/ccu_bit_rev.sv */
//==============================================================
// Purpose: bit order reversal by byte, half-word or word
// Assumes: data sits in the low bits for narrow accesses
// Notes: a narrow access never reverses across more bits than it has
//==============================================================
`timescale 1ns/1ps
`default_nettype none
module ccu_bit_rev
   import ccu_pkg::*;
(
   input wire logic [31:0] data_in,
   input wire logic [1:0] mode,
   input wire ccu_size_t size,
   output logic [31:0] data_out
);
   logic [1:0] eff_mode;

   // clip the group size to the access size
   always_comb begin
      if (size == SIZE_BYTE && mode != REV_NONE) begin
         eff_mode = REV_BYTE;
      end else if (size == SIZE_HALF && mode == REV_WORD) begin
         eff_mode = REV_HALF;
      end else begin
         eff_mode = mode;
      end
   end

   // reverse inside each group
   always_comb begin
      data_out = data_in;
      for (int i = 0; i < 32; i++) begin
         case (eff_mode)
            REV_BYTE: data_out[i] = data_in[(i / 8) * 8 + 7 - (i % 8)];
            REV_HALF: data_out[i] = data_in[(i / 16) * 16 + 15 - (i % 16)];
            REV_WORD: data_out[i] = data_in[31 - i];
            default: data_out[i] = data_in[i];
         endcase
      end
   end
endmodule
`default_nettype wire

/* File: verilog/ccu_crc_step.sv */
//==============================================================
// Purpose: eight input bits of mod-2 division, msb first
// Assumes: remainder held in the low bits of the chosen width
// Notes: purely combinational, one byte per clock in the caller
//==============================================================
`timescale 1ns/1ps
`default_nettype none
module ccu_crc_step
   import ccu_pkg::*;
(
   input wire logic [31:0] crc_in,
   input wire logic [31:0] coeff,
   input wire logic [1:0] width_sel,
   input wire logic [7:0] data_byte,
   output logic [31:0] crc_out
);
   logic [31:0] mask;
   logic [4:0] top;
   logic fb;

   // width picks the feedback tap
   always_comb begin
      mask = ccu_width_mask(width_sel);
      case (width_sel)
         WSEL_16: top = 5'h0f;
         WSEL_8: top = 5'h07;
         WSEL_7: top = 5'h06;
         default: top = 5'h1f;
      endcase
   end

   // shift in one bit at a time, xor divisor on feedback
   always_comb begin
      crc_out = crc_in & mask;
      fb = 1'b0;
      for (int i = 7; i >= 0; i--) begin
         fb = crc_out[top] ^ data_byte[i];
         crc_out = (crc_out << 1) & mask;
         if (fb) begin
            crc_out = crc_out ^ (coeff & mask);
         end
      end
   end
endmodule
`default_nettype wire

/* File: verilog/ccu_pkg.sv */
//==============================================================
// Purpose: constants, carriers and helpers of the crc calculation unit
// Assumes: apb register bus, 32-bit data, one clock
// Notes: offsets are byte addresses on the bus
//==============================================================
package ccu_pkg;

   //==============================================================
   // register map
   localparam logic [7:0] ADDR_DATA = 8'h00;
   localparam logic [7:0] ADDR_SCRATCH = 8'h04;
   localparam logic [7:0] ADDR_CTRL = 8'h08;
   localparam logic [7:0] ADDR_INIT = 8'h10;
   localparam logic [7:0] ADDR_COEFF = 8'h14;

   //==============================================================
   // reset values
   localparam logic [31:0] RST_DATA = 32'hffffffff;
   localparam logic [7:0] RST_SCRATCH = 8'h00;
   localparam logic [31:0] RST_INIT = 32'hffffffff;
   localparam logic [31:0] RST_COEFF = 32'h04c11db7;

   //==============================================================
   // control field positions
   localparam int CTRL_RESET_BIT = 0;
   localparam int CTRL_WIDTH_LSB = 3;
   localparam int CTRL_INREV_LSB = 5;
   localparam int CTRL_OUTREV_BIT = 7;

   //==============================================================
   // field encodings
   localparam logic [1:0] WSEL_32 = 2'h0;
   localparam logic [1:0] WSEL_16 = 2'h1;
   localparam logic [1:0] WSEL_8 = 2'h2;
   localparam logic [1:0] WSEL_7 = 2'h3;
   localparam logic [1:0] REV_NONE = 2'h0;
   localparam logic [1:0] REV_BYTE = 2'h1;
   localparam logic [1:0] REV_HALF = 2'h2;
   localparam logic [1:0] REV_WORD = 2'h3;
   localparam logic [3:0] STRB_WORD = 4'hf;

   //==============================================================
   // timing: most cycles one step may take
   localparam int CALC_CYCLES_MAX = 4;

   typedef struct packed {
      logic output_reverse;
      logic [1:0] input_reverse_sel;
      logic [1:0] divisor_width_sel;
   } ccu_ctrl_t;

   typedef enum logic [1:0] {
      SIZE_BYTE = 2'h0,
      SIZE_HALF = 2'h1,
      SIZE_WORD = 2'h2
   } ccu_size_t;

   typedef enum logic {
      ST_IDLE = 1'b0,
      ST_CALC = 1'b1
   } ccu_state_t;

   // remainder bits in use for a divisor width
   function automatic logic [31:0] ccu_width_mask(input logic [1:0] sel);
      case (sel)
         WSEL_16: ccu_width_mask = 32'h0000ffff;
         WSEL_8: ccu_width_mask = 32'h000000ff;
         WSEL_7: ccu_width_mask = 32'h0000007f;
         default: ccu_width_mask = 32'hffffffff;
      endcase
   endfunction

endpackage

/* File: verilog/ccu_top.sv */
//==============================================================
// Purpose: crc calculation unit with apb register access
// Assumes: apb4 master, pstrb zero on reads, one clock
// Notes: each access gets one wait state, more while a step runs
//==============================================================
//
// The APB register port was decided locally.
`timescale 1ns/1ps
`default_nettype none
module ccu_top
   import ccu_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr
);

   //==============================================================
   // state
   logic [31:0] crc;
   logic [7:0] scratch_byte;
   ccu_ctrl_t ctrl;
   logic [31:0] init_value;
   logic [31:0] divisor_coeff;
   ccu_state_t state;
   logic [31:0] feed;
   logic [2:0] bytes_left;

   //==============================================================
   // decode
   logic access;
   logic commit;
   logic wr_commit;
   logic sel_data;
   logic sel_scratch;
   logic sel_ctrl;
   logic sel_init;
   logic sel_coeff;
   logic mapped;
   logic data_ok;
   logic [31:0] lane_val;
   ccu_size_t lane_size;
   logic acc_err;
   logic [31:0] rd_val;

   // response flop rises after one access cycle, commit on the next
   assign access = psel & penable;
   assign commit = access & pready;
   assign wr_commit = commit & pwrite & ~pslverr;

   // word aligned addresses only
   assign sel_data = (paddr == ADDR_DATA);
   assign sel_scratch = (paddr == ADDR_SCRATCH);
   assign sel_ctrl = (paddr == ADDR_CTRL);
   assign sel_init = (paddr == ADDR_INIT);
   assign sel_coeff = (paddr == ADDR_COEFF);
   assign mapped = sel_data | sel_scratch | sel_ctrl | sel_init | sel_coeff;

   // only written lanes enter the step
   always_comb begin
      data_ok = 1'b1;
      lane_val = 32'h00000000;
      lane_size = SIZE_WORD;
      case (pstrb)
         4'h1: begin
            lane_val = {24'h000000, pwdata[7:0]};
            lane_size = SIZE_BYTE;
         end
         4'h2: begin
            lane_val = {24'h000000, pwdata[15:8]};
            lane_size = SIZE_BYTE;
         end
         4'h4: begin
            lane_val = {24'h000000, pwdata[23:16]};
            lane_size = SIZE_BYTE;
         end
         4'h8: begin
            lane_val = {24'h000000, pwdata[31:24]};
            lane_size = SIZE_BYTE;
         end
         4'h3: begin
            lane_val = {16'h0000, pwdata[15:0]};
            lane_size = SIZE_HALF;
         end
         4'hc: begin
            lane_val = {16'h0000, pwdata[31:16]};
            lane_size = SIZE_HALF;
         end
         4'hf: begin
            lane_val = pwdata;
         end
         default: begin
            data_ok = 1'b0;
         end
      endcase
   end

   assign acc_err = ~mapped | (pwrite & sel_data & ~data_ok) | (pwrite & ~sel_data & (pstrb != STRB_WORD));

   //==============================================================
   // datapath instances
   logic [31:0] rev_in;
   logic [31:0] crc_view;
   logic [31:0] step_out;
   logic [1:0] out_mode;

   // byte groups handled in the reverser
   ccu_bit_rev u_in_rev (
      .data_in(lane_val),
      .mode(ctrl.input_reverse_sel),
      .size(lane_size),
      .data_out(rev_in)
   );

   // result is the remainder itself, no xor
   assign out_mode = ctrl.output_reverse ? REV_WORD : REV_NONE;
   ccu_bit_rev u_out_rev (
      .data_in(crc),
      .mode(out_mode),
      .size(SIZE_WORD),
      .data_out(crc_view)
   );

   ccu_crc_step u_step (
      .crc_in(crc),
      .coeff(divisor_coeff),
      .width_sel(ctrl.divisor_width_sel),
      .data_byte(feed[31:24]),
      .crc_out(step_out)
   );

   //==============================================================
   // read mux
   // data reads return the result
   always_comb begin
      rd_val = 32'h00000000;
      if (sel_data) begin
         rd_val = crc_view;
      end else if (sel_scratch) begin
         rd_val = {24'h000000, scratch_byte};
      end else if (sel_ctrl) begin
         rd_val[CTRL_OUTREV_BIT] = ctrl.output_reverse;
         rd_val[CTRL_INREV_LSB +: 2] = ctrl.input_reverse_sel;
         rd_val[CTRL_WIDTH_LSB +: 2] = ctrl.divisor_width_sel;
      end else if (sel_init) begin
         rd_val = init_value;
      end else if (sel_coeff) begin
         rd_val = divisor_coeff;
      end
   end

   //==============================================================
   // bus response
   // no answer while a step runs, so reads see the new result
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h00000000;
      end else if (pready) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h00000000;
      end else if (access && state == ST_IDLE) begin
         pready <= 1'b1;
         pslverr <= acc_err;
         prdata <= (pwrite || acc_err) ? 32'h00000000 : rd_val;
      end
   end

   //==============================================================
   // software registers
   // scratch untouched by the control reset bit
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         scratch_byte <= RST_SCRATCH;
      end else if (wr_commit && sel_scratch) begin
         scratch_byte <= pwdata[7:0];
      end
   end

   // control fields, reset bit is never stored
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl <= '0;
      end else if (wr_commit && sel_ctrl) begin
         ctrl.output_reverse <= pwdata[CTRL_OUTREV_BIT];
         ctrl.input_reverse_sel <= pwdata[CTRL_INREV_LSB +: 2];
         ctrl.divisor_width_sel <= pwdata[CTRL_WIDTH_LSB +: 2];
      end
   end

   // initial value register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         init_value <= RST_INIT;
      end else if (wr_commit && sel_init) begin
         init_value <= pwdata;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         divisor_coeff <= RST_COEFF;
      end else if (wr_commit && sel_coeff) begin
         divisor_coeff <= pwdata;
      end
   end

   //==============================================================
   // calculation sequencer, one byte per clock
   // a word takes four clocks, narrower writes fewer
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state <= ST_IDLE;
         feed <= 32'h00000000;
         bytes_left <= 3'h0;
      end else begin
         case (state)
            ST_IDLE: begin
               if (wr_commit && sel_data) begin
                  state <= ST_CALC;
                  // msb-align so the top byte goes first
                  case (lane_size)
                     SIZE_BYTE: begin
                        feed <= {rev_in[7:0], 24'h000000};
                        bytes_left <= 3'h1;
                     end
                     SIZE_HALF: begin
                        feed <= {rev_in[15:0], 16'h0000};
                        bytes_left <= 3'h2;
                     end
                     default: begin
                        feed <= rev_in;
                        bytes_left <= 3'h4;
                     end
                  endcase
               end
            end
            ST_CALC: begin
               feed <= {feed[23:0], 8'h00};
               bytes_left <= bytes_left - 3'h1;
               if (bytes_left == 3'h1) begin
                  state <= ST_IDLE;
               end
            end
            default: begin
               state <= ST_IDLE;
            end
         endcase
      end
   end

   // control reset reloads the initial value
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         crc <= RST_DATA;
      end else if (state == ST_CALC) begin
         crc <= step_out;
      end else if (wr_commit && sel_ctrl && pwdata[CTRL_RESET_BIT]) begin
         crc <= init_value & ccu_width_mask(pwdata[CTRL_WIDTH_LSB +: 2]);
      end
   end

   //==============================================================
   // checks
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   logic [2:0] calc_len;
   // cycles spent in one step
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         calc_len <= 3'h0;
      end else if (state == ST_CALC) begin
         calc_len <= calc_len + 3'h1;
      end else begin
         calc_len <= 3'h0;
      end
   end

   lane_refuse_a: assert property (pready && pwrite && !sel_data && mapped && pstrb != STRB_WORD |-> pslverr)
      else $error("partial write to a word register not refused");
   data_read_a: assert property (access && pready && !pwrite && sel_data |-> prdata == crc_view)
      else $error("data read does not return the result");
   scratch_keep_a: assert property (wr_commit && sel_ctrl && pwdata[0] |=> $stable(scratch_byte))
      else $error("scratch byte changed by control reset");
   out_reverse_a: assert property (ctrl.output_reverse |-> crc_view == 32'({<<{crc}}))
      else $error("output not word reversed");
   ctrl_read_a: assert property (pready && !pwrite && sel_ctrl |-> prdata[CTRL_RESET_BIT] == 1'b0)
      else $error("reset bit reads back as one");
   reset_load_a: assert property (wr_commit && sel_ctrl && pwdata[0] && pwdata[4:3] == WSEL_32
      |=> crc == $past(init_value))
      else $error("control reset did not load initial value");
   coeff_write_a: assert property (wr_commit && sel_coeff |=> divisor_coeff == $past(pwdata))
      else $error("coefficient write lost");
   step_bound_a: assert property (state == ST_CALC |-> calc_len < 3'(CALC_CYCLES_MAX))
      else $error("step ran past four cycles");
   word_len_a: assert property (wr_commit && sel_data && pstrb == STRB_WORD
      |=> (state == ST_CALC) [*4] ##1 state == ST_IDLE)
      else $error("word write did not take four steps");
   byte_len_a: assert property (wr_commit && sel_data && pstrb == 4'h1
      |=> state == ST_CALC ##1 state == ST_IDLE)
      else $error("byte write did not take one step");
   hold_off_a: assert property (state == ST_CALC |-> !pready)
      else $error("answer given while a step runs");
   carry_on_a: assert property (state == ST_CALC |=> crc == $past(step_out))
      else $error("remainder not carried into the step");

   word_write_c: cover property (wr_commit && sel_data && pstrb == STRB_WORD);
   stalled_read_c: cover property (access && !pwrite && sel_data && state == ST_CALC);
   ctrl_reset_c: cover property (wr_commit && sel_ctrl && pwdata[0]);
   unmapped_c: cover property (pready && pslverr && !mapped);

endmodule
`default_nettype wire
